// *** core/i2c_loader_pkg.sv ***
package i2c_loader_pkg;
  // ----------------------------------------
  // bus addresses and register map
  // ----------------------------------------
  localparam logic [6:0] DEV_ADDR7 = 7'h31;
  localparam logic [6:0] MEM_ADDR7 = 7'h50;
  localparam logic [15:0] REG_STATUS = 16'h0889;
  localparam logic [15:0] REG_SIGNATURE = 16'h088c;
  localparam logic [15:0] REG_CONTROL = 16'h088d;
  localparam logic [15:0] REG_VALID = 16'h088e;
  localparam logic [7:0] SIGNATURE_GOOD = 8'haa;
  localparam logic [7:0] VALID_SET = 8'h0a;
  localparam logic [7:0] VALID_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h01;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam logic [7:0] READ_EMPTY = 8'h00;
  localparam int PU_FLAG_BIT = 7;
  localparam int MASK_HI = 2;
  localparam int MAINT_HI = 5;
  localparam int MAINT_LO = 4;
  localparam logic [1:0] MAINT_ON = 2'h3;
  localparam logic [15:0] RANGE_FIRST [0:2] = '{16'h0000, 16'h0400, 16'h0880};
  localparam logic [15:0] RANGE_LAST [0:2] = '{16'h01ff, 16'h041f, 16'h088c};
  localparam logic [1:0] LAST_RANGE = 2'h2;
  // ----------------------------------------
  // bit framing
  // ----------------------------------------
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam logic [8:0] FRAME_IDLE = 9'h1ff;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SELFCFG_NS = 2500000;
  localparam int LINK_CLK_NS = 80;
  localparam int SYS_CLK_NS = 40;
  localparam int SCL_QTR_NS = 625;
  localparam int STRAP_TAP = 2;
  function automatic int cycles_up(input int ns, input int clk_ns);
    return (ns + clk_ns - 1) / clk_ns;
  endfunction : cycles_up
  localparam int SELFCFG_CYC = SELFCFG_NS / LINK_CLK_NS;
  localparam int LINK_QTR_CYC = cycles_up(SCL_QTR_NS, LINK_CLK_NS);
  localparam int SYS_QTR_CYC = cycles_up(SCL_QTR_NS, SYS_CLK_NS);
  // ----------------------------------------
  // state types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PU_SELFCFG = 2'b00,
    PU_LOAD = 2'b01,
    PU_RUN = 2'b10
  } pu_state_t;
  typedef enum logic [3:0] {
    LD_IDLE = 4'b0000, LD_S1 = 4'b0001, LD_DEVW = 4'b0010, LD_AHI = 4'b0011,
    LD_ALO = 4'b0100, LD_P1 = 4'b0101, LD_S2 = 4'b0110, LD_DEVR = 4'b0111,
    LD_RX = 4'b1000, LD_P2 = 4'b1001, LD_DONE = 4'b1010
  } ld_step_t;
  typedef enum logic [1:0] {
    SL_IDLE = 2'b00,
    SL_RX = 2'b01,
    SL_TX = 2'b10,
    SL_IGNORE = 2'b11
  } sl_state_t;
  typedef enum logic [3:0] {
    H_IDLE = 4'b0000, H_S1 = 4'b0001, H_DEVW = 4'b0010, H_ALO = 4'b0011,
    H_AHI = 4'b0100, H_DATA = 4'b0101, H_P1 = 4'b0110, H_S2 = 4'b0111,
    H_DEVR = 4'b1000, H_RX = 4'b1001, H_P2 = 4'b1010
  } h_step_t;
endpackage : i2c_loader_pkg

// *** core/i2c_link_if.sv ***
`timescale 1ns/1ps
interface i2c_link_if;
  // ----------------------------------------
  // open-drain drivers of both ends
  // ----------------------------------------
  logic scl_dev_o, scl_dev_oe, sda_dev_o, sda_dev_oe, irq_dev_o, irq_dev_oe;
  logic scl_host_o, scl_host_oe, sda_host_o, sda_host_oe;
  logic scl, sda, alarm_request_n;
  // wired-and with pull-ups
  assign scl = ~((scl_dev_oe & ~scl_dev_o) | (scl_host_oe & ~scl_host_o));
  assign sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_host_oe & ~sda_host_o));
  assign alarm_request_n = ~(irq_dev_oe & ~irq_dev_o);
  modport device (
    input scl, sda,
    output scl_dev_o, scl_dev_oe, sda_dev_o, sda_dev_oe, irq_dev_o, irq_dev_oe
  );
  modport host (
    input scl, sda, alarm_request_n,
    output scl_host_o, scl_host_oe, sda_host_o, sda_host_oe
  );
endinterface : i2c_link_if

// *** core/i2c_port_device.sv ***
// Summary of operation
// - maint field 00 disables, 11 enables outputs
// - software keeps reserved control bits at reset
// - power-up starts at reset, strap picks mode
// - power-up sets flag, pulls interrupt low
// - self-configuration runs about 2.5 ms first
// - master mode copies three memory ranges
// - memory addressed at fixed address 0x50
// - signature 0xaa after good load sets valid
// - master mode releases interrupt after load
// - slave mode releases interrupt after selfconfig
// - slave power-up leaves pixel config undefined
// - accesses ignored while interrupt held low
// - fast-mode slave, 7-bit address, basic features
// - start begins transaction, no repeated start
// - sample on scl rise, drive after fall
// - msb first, ninth clock carries acknowledge
// - slave address 0x31, bytes 0x62/0x63
// - write: address low first, then data
// - wrong address nacked until next start
// - read returns bytes from incrementing pointer
// - after master nack ignore until start
// - status flag held until read clears
`timescale 1ns/1ps
module i2c_port_device #(
  parameter int SELFCFG_CYCLES = i2c_loader_pkg::SELFCFG_CYC,
  parameter int MEM_DEPTH = 4096
) (
  i2c_link_if.device link,
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic mode_strap,
  output logic maint_out_en,
  output logic powerup_active
);
  import i2c_loader_pkg::*;
  localparam int AW = $clog2(MEM_DEPTH);
  localparam int CW = $clog2(SELFCFG_CYCLES + 1);
  localparam int QW = $clog2(LINK_QTR_CYC + 1);

  // ----------------------------------------
  // pin synchronisers and bus events
  // ----------------------------------------
  logic [1:0] scl_sync_reg, sda_sync_reg, strap_sync_reg;
  logic scl_prev_reg, sda_prev_reg;
  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire strap_s = strap_sync_reg[1];
  always_ff @(posedge link_clk) begin
    if (!rst_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      strap_sync_reg <= 2'h0;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], link.scl};
      sda_sync_reg <= {sda_sync_reg[0], link.sda};
      strap_sync_reg <= {strap_sync_reg[0], mode_strap};
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_prev_reg;
  wire scl_fall = ~scl_s & scl_prev_reg;
  wire start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  wire stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  // ----------------------------------------
  // power-up sequencer
  // ----------------------------------------
  pu_state_t pu_reg;
  ld_step_t ld_step_reg;
  logic [CW-1:0] cfg_cnt_reg;
  logic master_mode_reg;
  always_ff @(posedge link_clk) begin
    if (!rst_n) begin
      pu_reg <= PU_SELFCFG;
      cfg_cnt_reg <= '0;
      master_mode_reg <= 1'b0;
    end else begin
      case (pu_reg)
        PU_SELFCFG: begin
          cfg_cnt_reg <= cfg_cnt_reg + 1'b1;
          if (cfg_cnt_reg == CW'(STRAP_TAP)) master_mode_reg <= strap_s;
          if (cfg_cnt_reg == CW'(SELFCFG_CYCLES - 1)) pu_reg <= master_mode_reg ? PU_LOAD : PU_RUN;
        end
        PU_LOAD: if (ld_step_reg == LD_DONE) pu_reg <= PU_RUN;
        default: pu_reg <= PU_RUN;
      endcase
    end
  end
  wire pu_busy = (pu_reg != PU_RUN);

  // ----------------------------------------
  // configuration loader (bus master)
  // ----------------------------------------
  logic [QW-1:0] q_cnt_reg;
  logic [1:0] ph_reg, rng_reg;
  logic [3:0] bit_reg;
  logic [8:0] tx_reg, rx_reg;
  logic [15:0] addr_reg;
  logic fail_reg, m_scl_reg, m_sda_reg;
  logic [7:0] valid_reg;
  ld_step_t step_n;
  logic [15:0] addr_n;
  logic [1:0] rng_n;
  logic fail_n;
  wire q_tick = (q_cnt_reg == QW'(LINK_QTR_CYC - 1));
  wire is_start = (ld_step_reg == LD_S1) | (ld_step_reg == LD_S2);
  wire is_stop = (ld_step_reg == LD_P1) | (ld_step_reg == LD_P2);
  wire is_byte = ~is_start & ~is_stop;
  wire ld_active = (ld_step_reg != LD_IDLE) & (ld_step_reg != LD_DONE);
  wire act_end = ld_active & q_tick & (ph_reg == PH_LAST) & (~is_byte | (bit_reg == BIT_ACK));
  wire nack = rx_reg[0];
  wire last_n = (addr_n == RANGE_LAST[rng_n]);
  wire ld_wr = act_end & (ld_step_reg == LD_RX);
  wire m_scl_low = is_start ? (ph_reg >= PH_SAMPLE) : is_stop ? (ph_reg == 2'h0) :
                   (ph_reg == 2'h0) | (ph_reg == PH_LAST);
  wire m_sda_low = is_start ? (ph_reg != 2'h0) : is_stop ? (ph_reg < PH_SAMPLE) : ~tx_reg[8];

  // frame for each step, ack slot last
  function automatic logic [8:0] ld_frame(input ld_step_t s, input logic [15:0] a, input logic last);
    case (s)
      LD_DEVW: return {MEM_ADDR7, 1'b0, 1'b1};
      LD_AHI: return {a[15:8], 1'b1};
      LD_ALO: return {a[7:0], 1'b1};
      LD_DEVR: return {MEM_ADDR7, 1'b1, 1'b1};
      LD_RX: return {8'hff, last};
      default: return FRAME_IDLE;
    endcase
  endfunction : ld_frame

  // step sequencing over the three ranges
  always_comb begin
    step_n = ld_step_reg;
    addr_n = addr_reg;
    rng_n = rng_reg;
    fail_n = fail_reg;
    case (ld_step_reg)
      LD_S1: step_n = LD_DEVW;
      LD_DEVW: step_n = nack ? LD_P2 : LD_AHI;
      LD_AHI: step_n = nack ? LD_P2 : LD_ALO;
      LD_ALO: step_n = nack ? LD_P2 : LD_P1;
      LD_P1: step_n = LD_S2;
      LD_S2: step_n = LD_DEVR;
      LD_DEVR: step_n = nack ? LD_P2 : LD_RX;
      LD_RX: begin
        if (addr_reg == RANGE_LAST[rng_reg]) step_n = LD_P2;
        else addr_n = addr_reg + 16'h0001;
      end
      LD_P2: begin
        if (fail_reg | (rng_reg == LAST_RANGE)) begin
          step_n = LD_DONE;
        end else begin
          rng_n = rng_reg + 2'h1;
          addr_n = RANGE_FIRST[rng_n];
          step_n = LD_S1;
        end
      end
      default: step_n = ld_step_reg;
    endcase
    if (is_byte & (ld_step_reg != LD_RX) & nack) fail_n = 1'b1;
  end

  logic [7:0] mem [0:MEM_DEPTH-1];
  always_ff @(posedge link_clk) begin
    if (!rst_n) begin
      ld_step_reg <= LD_IDLE;
      q_cnt_reg <= '0;
      ph_reg <= 2'h0;
      bit_reg <= 4'h0;
      tx_reg <= FRAME_IDLE;
      rx_reg <= 9'h000;
      rng_reg <= 2'h0;
      addr_reg <= 16'h0000;
      fail_reg <= 1'b0;
      valid_reg <= VALID_RESET;
    end else if (ld_step_reg == LD_IDLE) begin
      if (pu_reg == PU_LOAD) ld_step_reg <= LD_S1;
      addr_reg <= RANGE_FIRST[0];
    end else if (ld_active) begin
      q_cnt_reg <= q_tick ? '0 : q_cnt_reg + 1'b1;
      if (q_tick) begin
        ph_reg <= ph_reg + 2'h1;
        // master samples sda with scl high
        if (is_byte & (ph_reg == PH_SAMPLE)) rx_reg <= {rx_reg[7:0], sda_s};
        if (is_byte & (ph_reg == PH_LAST)) begin
          tx_reg <= {tx_reg[7:0], 1'b1};
          bit_reg <= bit_reg + 4'h1;
        end
      end
      if (act_end) begin
        bit_reg <= 4'h0;
        ld_step_reg <= step_n;
        addr_reg <= addr_n;
        rng_reg <= rng_n;
        fail_reg <= fail_n;
        tx_reg <= ld_frame(step_n, addr_n, last_n);
        // signature check after a clean load
        if ((step_n == LD_DONE) & ~fail_reg & (mem[REG_SIGNATURE[AW-1:0]] == SIGNATURE_GOOD)) valid_reg <= VALID_SET;
      end
    end
  end

  // ----------------------------------------
  // slave engine
  // ----------------------------------------
  sl_state_t s_reg;
  logic [3:0] s_bcnt_reg;
  logic [7:0] s_sh_reg, s_tx_reg;
  logic [1:0] s_nbyte_reg;
  logic [15:0] ptr_reg;
  logic s_read_reg, s_sda_reg;
  logic [7:0] ctrl_reg, status_reg, rd_data;
  wire addr_match = (s_sh_reg[7:1] == DEV_ADDR7);
  wire ack_slot = scl_fall & (s_reg == SL_RX) & (s_bcnt_reg == BIT_ACK);
  wire s_wr = ack_slot & (s_nbyte_reg == 2'h3);
  wire tx_load = scl_fall & (s_bcnt_reg == BIT_END) & ((s_reg == SL_TX) | ((s_reg == SL_RX) & s_read_reg));
  // only a bus read of the status clears the flag
  wire status_rd = tx_load & (ptr_reg == REG_STATUS);
  assign rd_data = (ptr_reg == REG_STATUS) ? status_reg : (ptr_reg == REG_CONTROL) ? ctrl_reg :
                   (ptr_reg == REG_VALID) ? valid_reg :
                   (ptr_reg < 16'(MEM_DEPTH)) ? mem[ptr_reg[AW-1:0]] : READ_EMPTY;

  always_ff @(posedge link_clk) begin
    if (!rst_n | pu_busy) begin
      s_reg <= SL_IDLE;
      s_bcnt_reg <= 4'h0;
      s_sh_reg <= 8'h00;
      s_tx_reg <= 8'h00;
      s_nbyte_reg <= 2'h0;
      ptr_reg <= 16'h0000;
      s_read_reg <= 1'b0;
      s_sda_reg <= 1'b0;
    end else if (start_det) begin
      s_reg <= SL_RX;
      s_bcnt_reg <= 4'h0;
      s_nbyte_reg <= 2'h0;
      s_read_reg <= 1'b0;
      s_sda_reg <= 1'b0;
    end else if (stop_det) begin
      s_reg <= SL_IDLE;
      s_sda_reg <= 1'b0;
    end else if (scl_rise & ((s_reg == SL_RX) | (s_reg == SL_TX))) begin
      s_bcnt_reg <= s_bcnt_reg + 4'h1;
      if (s_bcnt_reg < BIT_ACK) s_sh_reg <= {s_sh_reg[6:0], sda_s};
      if ((s_reg == SL_TX) & (s_bcnt_reg == BIT_ACK) & sda_s) s_reg <= SL_IGNORE;
    end else if (ack_slot) begin
      if ((s_nbyte_reg == 2'h0) & ~addr_match) begin
        // wrong address, nack and go deaf
        s_reg <= SL_IGNORE;
        s_sda_reg <= 1'b0;
      end else begin
        s_sda_reg <= 1'b1;
        if (s_nbyte_reg != 2'h3) s_nbyte_reg <= s_nbyte_reg + 2'h1;
        if (s_nbyte_reg == 2'h0) s_read_reg <= s_sh_reg[0];
        if (s_nbyte_reg == 2'h1) ptr_reg[7:0] <= s_sh_reg;
        if (s_nbyte_reg == 2'h2) ptr_reg[15:8] <= s_sh_reg;
        if (s_wr) ptr_reg <= ptr_reg + 16'h0001;
      end
    end else if (tx_load) begin
      // next byte from pointer, then advance
      s_reg <= SL_TX;
      s_bcnt_reg <= 4'h0;
      s_sda_reg <= ~rd_data[7];
      s_tx_reg <= {rd_data[6:0], 1'b0};
      ptr_reg <= ptr_reg + 16'h0001;
    end else if (scl_fall & (s_reg == SL_RX) & (s_bcnt_reg == BIT_END)) begin
      s_bcnt_reg <= 4'h0;
      s_sda_reg <= 1'b0;
    end else if (scl_fall & (s_reg == SL_TX)) begin
      // drive zeros just after scl falls
      s_sda_reg <= (s_bcnt_reg < BIT_ACK) ? ~s_tx_reg[7] : 1'b0;
      s_tx_reg <= {s_tx_reg[6:0], 1'b0};
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  wire wr_en = ld_wr | s_wr;
  wire [15:0] wr_addr = ld_wr ? addr_reg : ptr_reg;
  wire [7:0] wr_data = ld_wr ? rx_reg[8:1] : s_sh_reg;
  // array has no reset, load fills it
  always_ff @(posedge link_clk) begin
    if (wr_en & (wr_addr < 16'(MEM_DEPTH))) mem[wr_addr[AW-1:0]] <= wr_data;
  end
  always_ff @(posedge link_clk) begin
    if (!rst_n) begin
      // power-up flag set from the start
      status_reg <= STATUS_RESET;
      ctrl_reg <= CONTROL_RESET;
    end else begin
      if (wr_en & (wr_addr == REG_CONTROL)) ctrl_reg <= wr_data;
      if (wr_en & (wr_addr == REG_STATUS)) status_reg[MASK_HI:0] <= wr_data[MASK_HI:0];
      if (status_rd) status_reg[PU_FLAG_BIT] <= 1'b0;
    end
  end

  // ----------------------------------------
  // output flops
  // ----------------------------------------
  logic sda_oe_reg, scl_oe_reg, irq_oe_reg, maint_reg;
  always_ff @(posedge link_clk) begin
    if (!rst_n) begin
      sda_oe_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      irq_oe_reg <= 1'b1;
      maint_reg <= 1'b0;
      m_scl_reg <= 1'b0;
      m_sda_reg <= 1'b0;
    end else begin
      m_scl_reg <= ld_active & m_scl_low;
      m_sda_reg <= ld_active & m_sda_low;
      sda_oe_reg <= m_sda_reg | s_sda_reg;
      scl_oe_reg <= m_scl_reg;
      irq_oe_reg <= pu_busy;
      // only 11 enables, forbidden codes stay off
      maint_reg <= (ctrl_reg[MAINT_HI:MAINT_LO] == MAINT_ON);
    end
  end
  assign link.sda_dev_oe = sda_oe_reg;
  assign link.scl_dev_oe = scl_oe_reg;
  assign link.irq_dev_oe = irq_oe_reg;
  assign link.sda_dev_o = 1'b0;
  assign link.scl_dev_o = 1'b0;
  assign link.irq_dev_o = 1'b0;
  assign maint_out_en = maint_reg;
  assign powerup_active = irq_oe_reg;
endmodule : i2c_port_device

// *** core/i2c_port_host.sv ***
`timescale 1ns/1ps
module i2c_port_host (
  i2c_link_if.host link,
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);
  import i2c_loader_pkg::*;
  localparam int QW = $clog2(SYS_QTR_CYC + 1);

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  logic [1:0] sda_sync_reg, irq_sync_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sda_sync_reg <= 2'h3;
      irq_sync_reg <= 2'h0;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], link.sda};
      irq_sync_reg <= {irq_sync_reg[0], link.alarm_request_n};
    end
  end
  wire sda_s = sda_sync_reg[1];
  wire irq_free = irq_sync_reg[1];

  // ----------------------------------------
  // command sequencer and scl divider
  // ----------------------------------------
  h_step_t step_reg, step_n;
  logic [QW-1:0] q_cnt_reg;
  logic [1:0] ph_reg;
  logic [3:0] bit_reg;
  logic [8:0] tx_reg, rx_reg;
  logic rd_reg, fail_reg, scl_reg, sda_reg, ready_reg, rsp_reg, nack_reg;
  logic [15:0] addr_reg;
  logic [7:0] wdata_reg, data_reg;
  wire q_tick = (q_cnt_reg == QW'(SYS_QTR_CYC - 1));
  wire is_start = (step_reg == H_S1) | (step_reg == H_S2);
  wire is_stop = (step_reg == H_P1) | (step_reg == H_P2);
  wire is_byte = ~is_start & ~is_stop;
  wire active = (step_reg != H_IDLE);
  wire act_end = active & q_tick & (ph_reg == PH_LAST) & (~is_byte | (bit_reg == BIT_ACK));
  wire nack = rx_reg[0] & (step_reg != H_RX);
  wire take = cmd_valid & ready_reg;
  wire scl_low = is_start ? (ph_reg >= PH_SAMPLE) : is_stop ? (ph_reg == 2'h0) :
                 (ph_reg == 2'h0) | (ph_reg == PH_LAST);
  wire sda_low = is_start ? (ph_reg != 2'h0) : is_stop ? (ph_reg < PH_SAMPLE) : ~tx_reg[8];

  // frame per step; pointer low byte first, read nacked
  function automatic logic [8:0] h_frame(input h_step_t s, input logic [15:0] a, input logic [7:0] d);
    case (s)
      H_DEVW: return {DEV_ADDR7, 1'b0, 1'b1};
      H_ALO: return {a[7:0], 1'b1};
      H_AHI: return {a[15:8], 1'b1};
      H_DATA: return {d, 1'b1};
      H_DEVR: return {DEV_ADDR7, 1'b1, 1'b1};
      default: return FRAME_IDLE;
    endcase
  endfunction : h_frame

  // write: S W lo hi data P; read: S W lo hi P S R data P
  always_comb begin
    step_n = step_reg;
    case (step_reg)
      H_S1: step_n = H_DEVW;
      H_DEVW: step_n = nack ? H_P2 : H_ALO;
      H_ALO: step_n = nack ? H_P2 : H_AHI;
      H_AHI: step_n = nack ? H_P2 : (rd_reg ? H_P1 : H_DATA);
      H_DATA: step_n = H_P2;
      H_P1: step_n = H_S2;
      H_S2: step_n = H_DEVR;
      H_DEVR: step_n = nack ? H_P2 : H_RX;
      H_RX: step_n = H_P2;
      H_P2: step_n = H_IDLE;
      default: step_n = H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      step_reg <= H_IDLE;
      q_cnt_reg <= '0;
      ph_reg <= 2'h0;
      bit_reg <= 4'h0;
      tx_reg <= FRAME_IDLE;
      rx_reg <= 9'h000;
      rd_reg <= 1'b0;
      fail_reg <= 1'b0;
      addr_reg <= 16'h0000;
      wdata_reg <= 8'h00;
      data_reg <= 8'h00;
    end else if (take) begin
      step_reg <= H_S1;
      rd_reg <= cmd_read;
      addr_reg <= cmd_addr;
      wdata_reg <= cmd_wdata;
      fail_reg <= 1'b0;
      q_cnt_reg <= '0;
      ph_reg <= 2'h0;
    end else if (active) begin
      q_cnt_reg <= q_tick ? '0 : q_cnt_reg + 1'b1;
      if (q_tick) begin
        ph_reg <= ph_reg + 2'h1;
        if (is_byte & (ph_reg == PH_SAMPLE)) rx_reg <= {rx_reg[7:0], sda_s};
        if (is_byte & (ph_reg == PH_LAST)) begin
          tx_reg <= {tx_reg[7:0], 1'b1};
          bit_reg <= bit_reg + 4'h1;
        end
      end
      if (act_end) begin
        bit_reg <= 4'h0;
        step_reg <= step_n;
        tx_reg <= h_frame(step_n, addr_reg, wdata_reg);
        if (is_byte & nack) fail_reg <= 1'b1;
        if (step_reg == H_RX) data_reg <= rx_reg[8:1];
      end
    end
  end

  // ----------------------------------------
  // output flops
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scl_reg <= 1'b0;
      sda_reg <= 1'b0;
      ready_reg <= 1'b0;
      rsp_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else begin
      scl_reg <= active & scl_low;
      sda_reg <= active & sda_low;
      // no access while the device holds its interrupt low
      ready_reg <= ~active & ~take & ~ready_reg & irq_free | (ready_reg & ~take & irq_free);
      rsp_reg <= act_end & (step_reg == H_P2);
      if (act_end & (step_reg == H_P2)) nack_reg <= fail_reg;
    end
  end
  assign link.scl_host_oe = scl_reg;
  assign link.sda_host_oe = sda_reg;
  assign link.scl_host_o = 1'b0;
  assign link.sda_host_o = 1'b0;
  assign cmd_ready = ready_reg;
  assign rsp_valid = rsp_reg;
  assign rsp_data = data_reg;
  assign rsp_nack = nack_reg;
endmodule : i2c_port_host

// *** tb/i2c_loader_props.sv ***
`timescale 1ns/1ps
module i2c_loader_props #(
  parameter int SELFCFG_CYCLES = i2c_loader_pkg::SELFCFG_CYC
) (
  input wire logic link_clk,
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic mode_strap,
  input wire logic scl,
  input wire logic alarm_request_n,
  input wire logic scl_dev_oe,
  input wire logic sda_dev_oe,
  input wire logic irq_dev_oe,
  input wire logic scl_host_oe,
  input wire logic sda_host_oe
);
  // ----------------------------------------
  // power-up and wire checks
  // ----------------------------------------
  int up_cnt;
  // link cycles since reset release, saturating
  always_ff @(posedge link_clk) begin
    if (!rst_n) up_cnt <= 0;
    else if (up_cnt < 100000) up_cnt <= up_cnt + 1;
  end
  a_irq_at_reset: assert property (@(posedge link_clk) disable iff (!rst_n)
    $rose(rst_n) |-> irq_dev_oe) else $error("interrupt not held at power-up");
  a_selfcfg_min_len: assert property (@(posedge link_clk) disable iff (!rst_n)
    $fell(irq_dev_oe) |-> up_cnt >= SELFCFG_CYCLES) else $error("self-config too short");
  a_slave_release: assert property (@(posedge link_clk) disable iff (!rst_n)
    !mode_strap && up_cnt == SELFCFG_CYCLES + 8 |-> !irq_dev_oe) else $error("interrupt not released");
  a_irq_stays_off: assert property (@(posedge link_clk) disable iff (!rst_n)
    $fell(irq_dev_oe) |=> !irq_dev_oe [*8]) else $error("interrupt pulled again");
  a_quiet_pwrup: assert property (@(posedge link_clk) disable iff (!rst_n)
    irq_dev_oe && !mode_strap |-> !sda_dev_oe) else $error("data driven during power-up");
  a_slave_no_scl: assert property (@(posedge link_clk) disable iff (!rst_n)
    !mode_strap |-> !scl_dev_oe) else $error("slave drove clock");
  a_sda_scl_low: assert property (@(posedge link_clk) disable iff (!rst_n)
    !mode_strap && $changed(sda_dev_oe) |-> !scl) else $error("data changed with clock high");
  a_host_waits: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !alarm_request_n |-> !scl_host_oe && !sda_host_oe) else $error("host active during power-up");
  c_release: cover property (@(posedge link_clk) disable iff (!rst_n) $fell(irq_dev_oe));
  c_dev_drive: cover property (@(posedge link_clk) disable iff (!rst_n) $rose(sda_dev_oe));
  c_host_clk: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(scl_host_oe));
endmodule : i2c_loader_props

// *** tb/i2c_port_with_powerup_loader_tb.sv ***
`timescale 1ns/1ps
module i2c_port_with_powerup_loader_tb;
  import i2c_loader_pkg::*;
  localparam int SELFCFG = 64;
  logic sys_clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, mode_strap = 1'b0;
  logic cmd_valid = 1'b0, cmd_read = 1'b0, cmd_ready, rsp_valid, rsp_nack, maint_out_en;
  logic [15:0] cmd_addr = 16'h0000;
  logic [7:0] cmd_wdata = 8'h00, rsp_data, rd;
  int err_total = 0, n_tests = 0;
  i2c_link_if link_bus ();
  i2c_port_device #(.SELFCFG_CYCLES(SELFCFG)) i_i2c_port_device (.link(link_bus), .link_clk(link_clk),
    .rst_n(rst_n), .mode_strap(mode_strap), .maint_out_en(maint_out_en), .powerup_active());
  i2c_port_host i_i2c_port_host (.link(link_bus), .sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  i2c_loader_props #(.SELFCFG_CYCLES(SELFCFG)) i_i2c_loader_props (.link_clk(link_clk), .sys_clk(sys_clk),
    .rst_n(rst_n), .mode_strap(mode_strap), .scl(link_bus.scl), .alarm_request_n(link_bus.alarm_request_n),
    .scl_dev_oe(link_bus.scl_dev_oe), .sda_dev_oe(link_bus.sda_dev_oe), .irq_dev_oe(link_bus.irq_dev_oe),
    .scl_host_oe(link_bus.scl_host_oe), .sda_host_oe(link_bus.sda_host_oe));
  // clocks, link clock unrelated in phase
  initial forever #20 sys_clk = ~sys_clk;
  initial begin
    #7;
    forever #40 link_clk = ~link_clk;
  end
  task automatic end_sim;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one command through the host, result in rd
  task automatic xfer(input logic rdn, input logic [15:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 20000) begin @(negedge sys_clk); n++; end
    cmd_valid = 1'b1; cmd_read = rdn; cmd_addr = a; cmd_wdata = wd;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20000) begin @(negedge sys_clk); n++; end
    rd = rsp_data;
    chk({7'h0, rsp_nack}, 8'h00);
  endtask : xfer
  task automatic t_powerup;
    int n;
    n = 0;
    chk({7'h0, link_bus.alarm_request_n}, 8'h00);
    while (link_bus.alarm_request_n !== 1'b1 && n < 10000) begin @(negedge sys_clk); n++; end
    chk({7'h0, n >= 2 * SELFCFG && n < 2 * SELFCFG + 40}, 8'h01);
  endtask : t_powerup
  task automatic t_status;
    xfer(1'b1, REG_STATUS, 8'h00);
    chk(rd, STATUS_RESET);
    xfer(1'b1, REG_STATUS, 8'h00);
    chk(rd, 8'h00);
  endtask : t_status
  task automatic t_maint;
    logic [1:0] codes [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
    logic [7:0] v;
    for (int c = 0; c < 4; c++) begin
      v = {2'b00, codes[c], 4'b0001};
      xfer(1'b0, REG_CONTROL, v);
      repeat (8) @(negedge sys_clk);
      chk({7'h0, maint_out_en}, {7'h0, codes[c] == MAINT_ON});
      xfer(1'b1, REG_CONTROL, 8'h00);
      chk(rd, v);
    end
  endtask : t_maint
  task automatic t_array;
    xfer(1'b0, 16'h0123, 8'h5a);
    xfer(1'b0, 16'h0124, 8'ha5);
    xfer(1'b1, 16'h0123, 8'h00);
    chk(rd, 8'h5a);
    xfer(1'b1, 16'h0124, 8'h00);
    chk(rd, 8'ha5);
    xfer(1'b1, REG_VALID, 8'h00);
    chk(rd, VALID_RESET);
  endtask : t_array
  // second power-up with strap high and no memory on the bus
  task automatic t_master;
    int n;
    rst_n = 1'b0;
    mode_strap = 1'b1;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    n = 0;
    chk({7'h0, link_bus.alarm_request_n}, 8'h00);
    chk({7'h0, maint_out_en}, 8'h00);
    while (link_bus.alarm_request_n !== 1'b1 && n < 10000) begin @(negedge sys_clk); n++; end
    chk({7'h0, n > 2 * SELFCFG + 650 && n < 2 * SELFCFG + 760}, 8'h01);
    xfer(1'b1, REG_VALID, 8'h00);
    chk(rd, VALID_RESET);
  endtask : t_master
  // main sequence
  initial begin
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    t_powerup();
    t_status();
    t_maint();
    t_array();
    t_master();
    end_sim();
  end
  // watchdog
  initial begin
    #3600000;
    err_total++;
    $display("mismatch %0t watchdog", $time);
    end_sim();
  end
endmodule : i2c_port_with_powerup_loader_tb
